// ### src/cmi_pkg.sv
// Constants, register map and state codes for the coax attachment unit.
// Assumes a 100 MHz core clock and a 10 Mb/s nominal bit rate.
package cmi_pkg;
    // Clock and bit cell.
    localparam int CLK_NS = 10;
    localparam int BIT_NS = 100;
    localparam int BIT_CYC = BIT_NS / CLK_NS;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam logic [3:0] BIT_LAST = 4'(BIT_CYC - 1);
    localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
    // Collision indication limits, in bit cells.
    localparam int SQE_ON_MAX_BITS = 9;
    localparam int SQE_OFF_MAX_BITS = 20;
    // Post-frame test: start window and length.
    localparam int TEST_DLY_NS = 600;
    localparam int TEST_LATE_NS = 1600;
    localparam int TEST_DLY_CYC = (TEST_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int TEST_LATE_CYC = TEST_LATE_NS / CLK_NS;
    localparam logic [7:0] DLY_LAST = 8'(TEST_DLY_CYC - 1);
    localparam logic [7:0] TEST_HOLD_BITS = 8'h0A;
    // Jabber window and isolate limit.
    localparam int JAB_WIN_MS = 20;
    localparam int JAB_MAX_MS = 150;
    localparam int JAB_WIN_CYC = JAB_WIN_MS * (1000000 / CLK_NS);
    localparam int ISO_MAX_MS = 20;
    localparam int JAB_W = 22;
    // Pin slots of the input synchroniser.
    localparam int PIN_N = 6;
    localparam int PIN_DOA = 0;
    localparam int PIN_DOB = 1;
    localparam int PIN_ISO = 2;
    localparam int PIN_RXA = 3;
    localparam int PIN_RXB = 4;
    localparam int PIN_COL = 5;
    // Register port.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CTRL_ISO = 0;
    localparam int CTRL_JCLR = 1;
    localparam int STAT_SQE = 0;
    localparam int STAT_JAB = 1;
    localparam int STAT_ISO = 2;
    localparam int STAT_COL = 3;
    localparam int STAT_TX = 4;
    localparam int STAT_RX = 5;
    localparam int STAT_TEST = 6;
    // Post-frame test sequencer.
    typedef enum logic [2:0] {
        TST_IDLE = 3'h1,
        TST_WAIT = 3'h2,
        TST_HOLD = 3'h4
    } cmi_tst_type;
endpackage : cmi_pkg

// ### src/cmi_tmr_if.sv
// Carrier between the control logic and its bit-cell timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface cmi_tmr_if;
    logic start;
    logic [7:0] nbits;
    logic busy;
    logic done;
    modport ctl (output start, output nbits, input busy, input done);
    modport tmr (input start, input nbits, output busy, output done);
endinterface : cmi_tmr_if
`default_nettype wire

// ### src/cmi_bit_timer.sv
// Bit-cell timer: counts a number of bit cells at the nominal rate.
// Assumes the start strobe is one cycle and comes from the same clock.
`timescale 1ns/1ps
`default_nettype none
module cmi_bit_timer (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    cmi_tmr_if.tmr tmr
);
    typedef struct packed {
        logic [3:0] pre;
        logic [7:0] cnt;
        logic busy;
        logic done;
    } cmi_tmr_st_type;

    cmi_tmr_st_type tmr_r;
    cmi_tmr_st_type tmr_nxt;

    always_comb
    begin
        tmr_nxt = tmr_r;
        if (i_ce)
        begin
            tmr_nxt.done = 1'b0;
            if (tmr.start)
            begin
                tmr_nxt.pre = 4'h0;
                tmr_nxt.cnt = tmr.nbits;
                tmr_nxt.busy = (tmr.nbits != 8'h00);
            end
            else if (tmr_r.busy)
            begin
                if (tmr_r.pre == cmi_pkg::BIT_LAST)
                begin
                    tmr_nxt.pre = 4'h0;
                    tmr_nxt.cnt = tmr_r.cnt - 8'h01;
                    if (tmr_r.cnt == 8'h01)
                    begin
                        tmr_nxt.busy = 1'b0;
                        tmr_nxt.done = 1'b1;
                    end
                end
                else
                begin
                    tmr_nxt.pre = tmr_r.pre + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            tmr_r <= '0;
        end
        else
        begin
            tmr_r <= tmr_nxt;
        end
    end

    assign tmr.busy = tmr_r.busy;
    assign tmr.done = tmr_r.done;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b || !i_ce);

    a_timer_ten_bits: assert property (
        tmr.start && tmr.nbits == 8'h0A |-> ##101 tmr.done)
        else $error("Bit timer did not end after ten bit cells.");
endmodule : cmi_bit_timer
`default_nettype wire

// ### src/cmi_mau.sv
// Control logic of a coax attachment unit facing the terminal interface.
// Assumes pin levels already decoded: activity and bit per circuit, a
// collision comparator level, and an isolate level decoded from CO.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cmi_mau #(
    parameter int JAB_WIN_CYC = cmi_pkg::JAB_WIN_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_do_act,
    input wire logic i_do_bit,
    input wire logic i_co_iso,
    input wire logic i_rx_act,
    input wire logic i_rx_bit,
    input wire logic i_coll_det,
    input wire logic [cmi_pkg::ADDR_W-1:0] i_addr,
    input wire logic [cmi_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [cmi_pkg::DATA_W-1:0] o_rdata,
    output logic o_tx_act,
    output logic o_tx_bit,
    output logic o_drv_en,
    output logic o_pos_dis,
    output logic o_di_act,
    output logic o_di_bit,
    output logic o_ci_sqe,
    output logic o_ci_cso,
    output logic o_jabber
);
    localparam logic [cmi_pkg::JAB_W-1:0] JAB_LAST =
        cmi_pkg::JAB_W'(JAB_WIN_CYC - 1);

    typedef struct packed {
        logic [cmi_pkg::PIN_N-1:0] s1;
        logic [cmi_pkg::PIN_N-1:0] s2;
        logic [cmi_pkg::PIN_N-1:0] s3;
        logic [cmi_pkg::PIN_N-1:0] filt;
        logic [cmi_pkg::JAB_W-1:0] jab_cnt;
        logic jab;
        logic iso_q;
        logic do_q;
        cmi_pkg::cmi_tst_type tst;
        logic [7:0] dly;
        logic [3:0] half;
        logic cso_ph;
        logic sqe;
        logic cso;
        logic drv_en;
        logic pos_dis;
        logic tx_act;
        logic tx_bit;
        logic di_act;
        logic di_bit;
        logic ctrl_iso;
        logic [cmi_pkg::DATA_W-1:0] rdata;
    } cmi_mau_st_type;

    cmi_mau_st_type mau_r;
    cmi_mau_st_type mau_nxt;
    cmi_tmr_if tmr_if ();

    logic [cmi_pkg::PIN_N-1:0] pins;
    logic iso_now;
    logic jab_lim;
    logic jab_set;
    logic jab_clr;
    logic jclr_wr;
    logic frame_end;
    logic coll;

    cmi_bit_timer u_bit_timer (
        .i_core_clk (i_core_clk),
        .i_rst_b (i_rst_b),
        .i_ce (i_ce),
        .tmr (tmr_if.tmr)
    );

    assign pins = {i_coll_det, i_rx_bit, i_rx_act, i_co_iso, i_do_bit,
        i_do_act};
    // A single fault-free path: the comparator threshold sits above one
    // transmitter's level, so this level is false with one or none active.
    assign coll = mau_r.filt[cmi_pkg::PIN_COL];
    assign iso_now = mau_r.filt[cmi_pkg::PIN_ISO] | mau_r.ctrl_iso;
    assign jab_lim = (mau_r.jab_cnt == JAB_LAST);
    assign jab_set = mau_r.filt[cmi_pkg::PIN_DOA] && !mau_r.jab && jab_lim;
    assign jclr_wr = i_wr && (i_addr == cmi_pkg::REG_CTRL)
        && i_wdata[cmi_pkg::CTRL_JCLR];
    assign jab_clr = (iso_now && !mau_r.iso_q) || jclr_wr;
    assign frame_end = mau_r.do_q && !mau_r.filt[cmi_pkg::PIN_DOA];
    assign tmr_if.start = i_ce && (mau_r.tst == cmi_pkg::TST_WAIT)
        && (mau_r.dly == cmi_pkg::DLY_LAST);
    assign tmr_if.nbits = cmi_pkg::TEST_HOLD_BITS;

    always_comb
    begin
        mau_nxt = mau_r;
        if (i_ce)
        begin
            // Only the second stage reads the first; a change is taken
            // once the second and third stages agree.
            mau_nxt.s1 = pins;
            mau_nxt.s2 = mau_r.s1;
            mau_nxt.s3 = mau_r.s2;
            for (int i = 0; i < cmi_pkg::PIN_N; i++)
            begin
                if (mau_r.s2[i] == mau_r.s3[i])
                begin
                    mau_nxt.filt[i] = mau_r.s2[i];
                end
            end

            // Jabber window runs while output data is present.
            if (!mau_r.filt[cmi_pkg::PIN_DOA])
            begin
                mau_nxt.jab_cnt = '0;
            end
            else if (!mau_r.jab && !jab_lim)
            begin
                mau_nxt.jab_cnt = mau_r.jab_cnt + 1'b1;
            end
            // Set wins over a clear arriving in the same cycle.
            if (jab_set)
            begin
                mau_nxt.jab = 1'b1;
            end
            else if (jab_clr)
            begin
                mau_nxt.jab = 1'b0;
            end
            mau_nxt.iso_q = iso_now;

            // Transmit side: isolation forces the positive disable and
            // cuts the driver; the receive path is not touched by it.
            mau_nxt.pos_dis = iso_now;
            mau_nxt.drv_en = mau_r.filt[cmi_pkg::PIN_DOA] && !mau_nxt.jab
                && !iso_now;
            mau_nxt.tx_act = mau_nxt.drv_en;
            mau_nxt.tx_bit = mau_nxt.drv_en
                && mau_r.filt[cmi_pkg::PIN_DOB];

            // Receive path is a plain delay, with no bit recovery.
            mau_nxt.di_act = mau_r.filt[cmi_pkg::PIN_RXA];
            mau_nxt.di_bit = mau_r.filt[cmi_pkg::PIN_RXA]
                && mau_r.filt[cmi_pkg::PIN_RXB];

            // Post-frame test sequencer.
            mau_nxt.do_q = mau_r.filt[cmi_pkg::PIN_DOA];
            case (mau_r.tst)
                cmi_pkg::TST_IDLE:
                begin
                    if (frame_end && !mau_r.jab)
                    begin
                        mau_nxt.tst = cmi_pkg::TST_WAIT;
                        mau_nxt.dly = 8'h00;
                    end
                end
                cmi_pkg::TST_WAIT:
                begin
                    if (mau_r.dly == cmi_pkg::DLY_LAST)
                    begin
                        mau_nxt.tst = cmi_pkg::TST_HOLD;
                    end
                    else
                    begin
                        mau_nxt.dly = mau_r.dly + 8'h01;
                    end
                end
                cmi_pkg::TST_HOLD:
                begin
                    if (tmr_if.done)
                    begin
                        mau_nxt.tst = cmi_pkg::TST_IDLE;
                    end
                end
                default:
                begin
                    mau_nxt.tst = cmi_pkg::TST_IDLE;
                end
            endcase

            // Error indication, independent of whether DO carries data.
            mau_nxt.sqe = coll
                || (mau_r.tst == cmi_pkg::TST_HOLD)
                || mau_r.jab;

            // Tone at the bit rate while indicating, idle otherwise.
            if (!mau_nxt.sqe)
            begin
                mau_nxt.half = 4'h0;
                mau_nxt.cso_ph = 1'b1;
            end
            else if (mau_r.half == cmi_pkg::HALF_LAST)
            begin
                mau_nxt.half = 4'h0;
                mau_nxt.cso_ph = !mau_r.cso_ph;
            end
            else
            begin
                mau_nxt.half = mau_r.half + 4'h1;
            end
            mau_nxt.cso = mau_nxt.sqe && mau_r.cso_ph;

            // Register port.
            if (i_wr && i_addr == cmi_pkg::REG_CTRL)
            begin
                mau_nxt.ctrl_iso = i_wdata[cmi_pkg::CTRL_ISO];
            end
            mau_nxt.rdata = '0;
            if (i_rd)
            begin
                case (i_addr)
                    cmi_pkg::REG_CTRL:
                    begin
                        mau_nxt.rdata[cmi_pkg::CTRL_ISO] = mau_r.ctrl_iso;
                    end
                    cmi_pkg::REG_STAT:
                    begin
                        mau_nxt.rdata[cmi_pkg::STAT_SQE] = mau_r.sqe;
                        mau_nxt.rdata[cmi_pkg::STAT_JAB] = mau_r.jab;
                        mau_nxt.rdata[cmi_pkg::STAT_ISO] = mau_r.pos_dis;
                        mau_nxt.rdata[cmi_pkg::STAT_COL] = coll;
                        mau_nxt.rdata[cmi_pkg::STAT_TX] = mau_r.tx_act;
                        mau_nxt.rdata[cmi_pkg::STAT_RX] = mau_r.di_act;
                        mau_nxt.rdata[cmi_pkg::STAT_TEST] =
                            (mau_r.tst == cmi_pkg::TST_HOLD);
                    end
                    default:
                    begin
                        mau_nxt.rdata = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            mau_r <= '0;
            mau_r.tst <= cmi_pkg::TST_IDLE;
            mau_r.cso_ph <= 1'b1;
            mau_r.ctrl_iso <= cmi_pkg::CTRL_RST[cmi_pkg::CTRL_ISO];
        end
        else
        begin
            mau_r <= mau_nxt;
        end
    end

    assign o_rdata = mau_r.rdata;
    assign o_tx_act = mau_r.tx_act;
    assign o_tx_bit = mau_r.tx_bit;
    assign o_drv_en = mau_r.drv_en;
    assign o_pos_dis = mau_r.pos_dis;
    assign o_di_act = mau_r.di_act;
    assign o_di_bit = mau_r.di_bit;
    assign o_ci_sqe = mau_r.sqe;
    assign o_ci_cso = mau_r.cso;
    assign o_jabber = mau_r.jab;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b || !i_ce);

    a_sqe_onset_bound: assert property (
        $rose(coll) |-> ##1 o_ci_sqe)
        else $error("Collision indication started late.");
    a_sqe_release_bound: assert property (
        $fell(coll) && !o_jabber && mau_r.tst == cmi_pkg::TST_IDLE
        |-> ##1 !o_ci_sqe)
        else $error("Collision indication held too long.");
    a_sqe_single_tx: assert property (
        !coll && !mau_r.jab && mau_r.tst != cmi_pkg::TST_HOLD
        |=> !o_ci_sqe && !o_ci_cso)
        else $error("Error indicated with at most one transmitter.");
    a_cso_tone_rate: assert property (
        o_ci_sqe [*6] |-> $changed(o_ci_cso) || $past(o_ci_cso, 5) != o_ci_cso)
        else $error("Error tone not at the bit rate.");
    a_jab_sqe_held: assert property (
        o_jabber |=> o_ci_sqe)
        else $error("Jabber inhibit without error indication.");
    a_jab_window_end: assert property (
        $rose(o_jabber) |-> $past(jab_lim) && $past(mau_r.filt[0]))
        else $error("Jabber set outside the window limit.");
    a_iso_tx_off: assert property (
        iso_now |=> o_pos_dis && !o_drv_en && !o_tx_act)
        else $error("Isolate did not disable the transmitter.");
    a_drv_exclusive: assert property (
        o_drv_en |-> !o_pos_dis)
        else $error("Driver enabled while positively disabled.");
    a_rx_passthru: assert property (
        mau_r.filt[cmi_pkg::PIN_RXA] |=>
        o_di_act && o_di_bit == $past(mau_r.filt[cmi_pkg::PIN_RXB]))
        else $error("Received bit not passed to DI.");
    a_rx_idle_out: assert property (
        !mau_r.filt[cmi_pkg::PIN_RXA] |=> !o_di_act && !o_di_bit)
        else $error("DI not idle without received data.");
    a_test_start_gap: assert property (
        $rose(mau_r.tst == cmi_pkg::TST_WAIT)
        |-> ##60 mau_r.tst == cmi_pkg::TST_HOLD)
        else $error("Post-frame test started at the wrong time.");
    a_test_hold_len: assert property (
        $rose(mau_r.tst == cmi_pkg::TST_HOLD)
        |-> ##101 mau_r.tst == cmi_pkg::TST_IDLE)
        else $error("Post-frame test length wrong.");
    a_test_timer_run: assert property (
        mau_r.tst == cmi_pkg::TST_HOLD |-> tmr_if.busy || tmr_if.done)
        else $error("Post-frame test held without a running timer.");

    c_post_frame_test: cover property (
        $rose(mau_r.tst == cmi_pkg::TST_HOLD));
    c_collision_seen: cover property ($rose(coll) ##1 o_ci_sqe);
    c_jabber_trip: cover property ($rose(o_jabber));
    c_isolate_on: cover property ($rose(o_pos_dis));
endmodule : cmi_mau
`default_nettype wire

// ### sim/cmi_dte_model.sv
// Terminal side model: drives DO and CO toward the attachment unit.
// Assumes its tasks are called from the core clock domain of the bench.
`timescale 1ns/1ps
`default_nettype none
module cmi_dte_model (
    input wire logic i_core_clk,
    output logic o_do_act = 1'b0,
    output logic o_do_bit = 1'b0,
    output logic o_co_iso = 1'b0
);
    logic act_v = 1'b0;
    logic bit_v = 1'b0;
    logic iso_v = 1'b0;
    // Idle DO carries no value, so its bit wanders instead of holding.
    always @(posedge i_core_clk)
    begin
        o_do_act <= act_v;
        o_do_bit <= act_v ? bit_v : ~o_do_bit;
        o_co_iso <= iso_v;
    end
    // One data bit held for a full bit cell of ten clocks.
    task automatic put_bit(input logic b);
        #1;
        act_v = 1'b1;
        bit_v = b;
        repeat (10) @(posedge i_core_clk);
    endtask : put_bit
    task automatic go_idle();
        #1;
        act_v = 1'b0;
        @(posedge i_core_clk);
    endtask : go_idle
    task automatic set_iso(input logic v);
        #1;
        iso_v = v;
        @(posedge i_core_clk);
    endtask : set_iso
endmodule : cmi_dte_model
`default_nettype wire

// ### sim/cmi_mau_test.sv
// Self-checking bench for the coax attachment unit control logic.
// Assumes the terminal model drives DO and CO; the bench plays the medium.
`timescale 1ns/1ps
`default_nettype none
module cmi_mau_test;
    localparam int JAB_CYC = 200;
    logic clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_rx_act = 1'b0;
    logic i_rx_bit = 1'b0;
    logic i_coll_det = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic ce = 1'b1;
    logic do_act, do_bit, co_iso;
    logic [31:0] o_rdata;
    logic o_tx_act, o_tx_bit, o_drv_en, o_pos_dis, o_di_act, o_di_bit;
    logic o_ci_sqe, o_ci_cso, o_jabber;
    logic rx_act_v = 1'b0;
    logic rx_bit_v = 1'b0;
    logic col_v = 1'b0;
    logic [31:0] seed = 32'h0aa1_6d86;
    logic q[$];
    int miscompares = 0;
    int compares = 0;
    int n;
    cmi_dte_model dte (.i_core_clk(clk), .o_do_act(do_act),
        .o_do_bit(do_bit), .o_co_iso(co_iso));
    cmi_mau #(.JAB_WIN_CYC(JAB_CYC)) dut (.i_core_clk(clk),
        .i_rst_b(i_rst_b), .i_ce(ce), .i_do_act(do_act),
        .i_do_bit(do_bit), .i_co_iso(co_iso), .i_rx_act(i_rx_act),
        .i_rx_bit(i_rx_bit), .i_coll_det(i_coll_det), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_tx_act(o_tx_act), .o_tx_bit(o_tx_bit), .o_drv_en(o_drv_en),
        .o_pos_dis(o_pos_dis), .o_di_act(o_di_act), .o_di_bit(o_di_bit),
        .o_ci_sqe(o_ci_sqe), .o_ci_cso(o_ci_cso), .o_jabber(o_jabber));
    initial
    begin
        forever #5 clk = ~clk;
    end
    // The medium line wanders when idle so a stale bit cannot pass.
    always @(posedge clk)
    begin
        i_rx_act <= rx_act_v;
        i_rx_bit <= rx_act_v ? rx_bit_v : ~i_rx_bit;
        i_coll_det <= col_v;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string w, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge clk);
        i_rd <= 1'b0;
        #2;
        chk("rdata", e, o_rdata);
        @(posedge clk);
        #2;
        chk("rdata_clr", 0, o_rdata);
    endtask : rd
    // Bounded wait for the error level; n is the clocks spent.
    task automatic wait_sqe(input logic lvl, input int lim);
        n = 0;
        while (o_ci_sqe !== lvl && n < lim)
        begin
            @(posedge clk);
            #2;
            n++;
        end
    endtask : wait_sqe
    task automatic coll_test(input logic [31:0] st);
        int tg;
        logic last;
        #1;
        col_v = 1'b1;
        wait_sqe(1'b1, 90);
        chk("sqe_rise", 1, 32'(n < 90));
        rd(cmi_pkg::REG_STAT, st);
        tg = 0;
        last = o_ci_cso;
        repeat (40)
        begin
            @(posedge clk);
            #2;
            tg += int'(o_ci_cso !== last);
            last = o_ci_cso;
        end
        chk("cso_tone", 1, 32'(tg >= 7 && tg <= 8));
        #1;
        col_v = 1'b0;
        wait_sqe(1'b0, 200);
        chk("sqe_fall", 1, 32'(n < 200));
        chk("ci_idle", 0, 32'(o_ci_cso));
    endtask : coll_test
    task automatic rx_frame(input int nb);
        repeat (nb)
        begin
            #1;
            rx_act_v = 1'b1;
            rx_bit_v = 1'(rnd());
            q.push_back(rx_bit_v);
            repeat (10) @(posedge clk);
            #2;
            chk("di_act", 1, 32'(o_di_act));
            chk("di_bit", 32'(q.pop_front()), 32'(o_di_bit));
        end
        #1;
        rx_act_v = 1'b0;
        repeat (10) @(posedge clk);
        #2;
        chk("di_idle", 0, 32'({o_di_act, o_di_bit}));
    endtask : rx_frame
    task automatic tx_frame(input int nb, input logic col);
        logic b;
        for (int i = 0; i < nb; i++)
        begin
            b = 1'(rnd());
            dte.put_bit(b);
            #2;
            chk("tx_act", 1, 32'({o_tx_act, o_drv_en} == 2'b11));
            chk("tx_bit", 32'(b), 32'(o_tx_bit));
            if (!col)
            begin
                chk("no_sqe", 0, 32'(o_ci_sqe));
            end
            else if (i == 4)
            begin
                coll_test(32'h0000_0019);
            end
        end
        dte.go_idle();
        wait_sqe(1'b1, 300);
        chk("test_start", 1, 32'(n >= 60 && n <= 160));
        rd(cmi_pkg::REG_STAT, 32'h0000_0041);
        wait_sqe(1'b0, 300);
        chk("test_len", 1, 32'(n >= 50 && n <= 150));
    endtask : tx_frame
    initial
    begin
        repeat (4) @(posedge clk);
        i_rst_b <= 1'b1;
        @(posedge clk);
        #2;
        chk("reset_out", 0, 32'({o_tx_act, o_drv_en, o_pos_dis,
            o_di_act, o_ci_sqe, o_ci_cso, o_jabber}));
        rd(cmi_pkg::REG_CTRL, cmi_pkg::CTRL_RST);
        rd(cmi_pkg::REG_STAT, 32'h0000_0000);
        wr(4'h8, 32'hffff_ffff);
        rd(4'h8, 32'h0000_0000);
        rd(cmi_pkg::REG_CTRL, 32'h0000_0000);
        rx_frame(12);
        coll_test(32'h0000_0009);
        tx_frame(16, 1'b0);
        tx_frame(12, 1'b1);
        dte.set_iso(1'b1);
        repeat (10) @(posedge clk);
        #2;
        chk("iso_dis", 2'b10, 32'({o_pos_dis, o_drv_en}));
        rx_frame(4);
        coll_test(32'h0000_000d);
        dte.set_iso(1'b0);
        repeat (10) @(posedge clk);
        #2;
        chk("iso_off", 0, 32'(o_pos_dis));
        wr(cmi_pkg::REG_CTRL, 32'h0000_0001);
        repeat (8) @(posedge clk);
        #2;
        chk("reg_iso", 1, 32'(o_pos_dis));
        rd(cmi_pkg::REG_CTRL, 32'h0000_0001);
        wr(cmi_pkg::REG_CTRL, 32'h0000_0000);
        repeat (8) @(posedge clk);
        #2;
        chk("reg_rel", 0, 32'(o_pos_dis));
        for (int i = 0; i < 30; i++)
        begin
            dte.put_bit(1'(rnd()));
            #2;
            if (i == 17)
            begin
                chk("jab_early", 0, 32'(o_jabber));
            end
            if (i == 24)
            begin
                chk("jab_on", 4'b1001, 32'({o_jabber, o_drv_en,
                    o_tx_act, o_ci_sqe}));
            end
        end
        dte.go_idle();
        repeat (50) @(posedge clk);
        #2;
        chk("jab_hold", 2'b11, 32'({o_jabber, o_ci_sqe}));
        // A jabber clear written while the clock enable is low is refused.
        @(posedge clk);
        ce <= 1'b0;
        wr(cmi_pkg::REG_CTRL, 32'h0000_0002);
        ce <= 1'b1;
        #2;
        chk("ce_hold", 2'b11, 32'({o_jabber, o_ci_sqe}));
        wr(cmi_pkg::REG_CTRL, 32'h0000_0002);
        wait_sqe(1'b0, 20);
        chk("jab_clr", 0, 32'({o_jabber, o_ci_sqe}));
        rd(cmi_pkg::REG_CTRL, 32'h0000_0000);
        stop_test();
    end
    // Whole run needs well under 10000 clocks.
    initial
    begin
        #400_000;
        miscompares++;
        stop_test();
    end
endmodule : cmi_mau_test
`default_nettype wire
